// file: hw/rer_pkg.sv
// constants and bit layout for the remote error status register bank
// What this block does
// - eight-bit error register, bit 7 unused
// - error bits fold unmasked into event flags
// - clear-status clears status, event, error together
// - error query read clears all error bits
// - bit 6 set on overlong message
// - bit 5 set on unknown header
// - bit 4 set on bad parameter format/count
// - bit 3 set on out-of-range parameter
// - bit 2 set on unexecutable command
// - bit 1 set on internal link fault
// - bit 0 set on damaged backup memory
// - event bit 5 flags syntactic/semantic faults
// - enabled event bit sets status bit 5
package rer_pkg;
  localparam int unsigned        REG_W         = 8;
  // error register bit positions
  localparam int unsigned        ERR_MSG_LONG  = 6;
  localparam int unsigned        ERR_HEADER    = 5;
  localparam int unsigned        ERR_FORMAT    = 4;
  localparam int unsigned        ERR_RANGE     = 3;
  localparam int unsigned        ERR_NO_EXEC   = 2;
  localparam int unsigned        ERR_LINK      = 1;
  localparam int unsigned        ERR_BACKUP    = 0;
  localparam logic [7:0]         ERR_USED_MASK = 8'h7f;
  // standard event register bit positions
  localparam int unsigned        EVT_POWER_ON  = 7;
  localparam int unsigned        EVT_CMD_ERR   = 5;
  localparam int unsigned        EVT_EXEC_ERR  = 4;
  localparam int unsigned        EVT_DEV_ERR   = 3;
  localparam int unsigned        EVT_QUERY_ERR = 2;
  localparam int unsigned        EVT_OP_DONE   = 0;
  // status byte summary bit
  localparam int unsigned        STB_EVT_SUM   = 5;
  // reset values
  localparam logic [7:0]         ERR_RESET     = 8'h00;
  localparam logic [7:0]         EVT_RESET     = 8'h80;
  localparam logic [7:0]         MASK_RESET    = 8'h00;
  // controller spacing between serial commands
  localparam int unsigned        CMD_GAP_MS    = 100;
  localparam int unsigned        CLK_HZ        = 50_000_000;
  localparam int unsigned        CMD_GAP_CYC   = CMD_GAP_MS * (CLK_HZ / 1000);
endpackage

// file: hw/rer_error_bank.sv
// error register and standard event register with query and clear
`timescale 1ns/100ps
module rer_error_bank (
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  // error events from the command parser, one-cycle pulses
  input  wire logic                        msg_too_long_flag_i,
  input  wire logic                        bad_header_flag_i,
  input  wire logic                        bad_format_flag_i,
  input  wire logic                        out_of_range_flag_i,
  input  wire logic                        cannot_execute_flag_i,
  input  wire logic                        internal_link_fault_flag_i,
  input  wire logic                        backup_damaged_flag_i,
  // other event sources, one-cycle pulses
  input  wire logic                        query_fault_i,
  input  wire logic                        op_done_i,
  // commands: clear status, error query, event query
  input  wire logic                        clear_status_i,
  input  wire logic                        error_query_i,
  input  wire logic                        event_query_i,
  input  wire logic [rer_pkg::REG_W-1:0]   event_enable_i,
  // answers
  output logic      [rer_pkg::REG_W-1:0]   error_data_o,
  output logic                             error_valid_o,
  output logic      [rer_pkg::REG_W-1:0]   event_data_o,
  output logic                             event_valid_o,
  output logic      [rer_pkg::REG_W-1:0]   error_flags_o,
  output logic      [rer_pkg::REG_W-1:0]   event_flags_o,
  output logic                             event_summary_o,
  output logic                             status_clear_o
);
  import rer_pkg::*;

  // behaviour in short:
  // - parser pulses set error bits, which stay until cleared
  // - error classes fold into the event register as they arrive
  // - an error query answers with the value from before the clear
  //   and empties both registers on the same edge
  // - an event query answers and empties the event register only
  // - clear-status empties both and pulses status_clear_o once
  // - an event landing on a clearing edge is kept, not lost
  // - answers come one cycle after the query and hold until the
  //   next query of the same kind; valid is a one-cycle pulse
  // limitation: the summary follows the enables combinationally,
  // so a glitchy enable source shows on the summary as well

  // stored registers and their next values
  logic [REG_W-1:0] err_r;
  logic [REG_W-1:0] err_nxt;
  logic [REG_W-1:0] evt_r;
  logic [REG_W-1:0] evt_nxt;
  // answer registers' next values
  logic [REG_W-1:0] error_data_nxt;
  logic [REG_W-1:0] event_data_nxt;
  // this cycle's events, raw and after the bit 7 mask
  logic [REG_W-1:0] err_src;
  logic [REG_W-1:0] err_set;
  logic [REG_W-1:0] evt_set;
  // clear strobes, one per register
  logic             err_clear;
  logic             evt_clear;

  // error classes to event classes, no enable mask in between
  function automatic logic [REG_W-1:0] fold_errors(
    input logic [REG_W-1:0] errs
  );
    logic [REG_W-1:0] evts;
    evts               = '0;
    evts[EVT_CMD_ERR]  = |errs[ERR_MSG_LONG:ERR_FORMAT];
    evts[EVT_EXEC_ERR] = errs[ERR_RANGE] | errs[ERR_NO_EXEC];
    evts[EVT_DEV_ERR]  = errs[ERR_LINK] | errs[ERR_BACKUP];
    return evts;
  endfunction

  // set wins over clear, so an event in the clearing cycle survives
  function automatic logic [REG_W-1:0] merge_flags(
    input logic [REG_W-1:0] held,
    input logic [REG_W-1:0] fresh,
    input logic             clear
  );
    logic [REG_W-1:0] merged;
    if (clear) begin
      merged = fresh;
    end else begin
      merged = held | fresh;
    end
    return merged;
  endfunction

  // answer register keeps its value until the next query of its kind
  function automatic logic [REG_W-1:0] capture_answer(
    input logic [REG_W-1:0] held,
    input logic [REG_W-1:0] live,
    input logic             query
  );
    logic [REG_W-1:0] answer;
    if (query) begin
      answer = live;
    end else begin
      answer = held;
    end
    return answer;
  endfunction

  // parser pulses placed at their error bit positions
  always_comb begin
    err_src               = '0;
    err_src[ERR_MSG_LONG] = msg_too_long_flag_i;
    err_src[ERR_HEADER]   = bad_header_flag_i;
    err_src[ERR_FORMAT]   = bad_format_flag_i;
    err_src[ERR_RANGE]    = out_of_range_flag_i;
    err_src[ERR_NO_EXEC]  = cannot_execute_flag_i;
    err_src[ERR_LINK]     = internal_link_fault_flag_i;
    err_src[ERR_BACKUP]   = backup_damaged_flag_i;
  end

  // bit 7 has no source; the mask keeps it dead if one is added
  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi = gi + 1) begin : g_err_mask
      assign err_set[gi] = err_src[gi] & ERR_USED_MASK[gi];
    end
  endgenerate

  // query errors and completions enter the event register directly
  always_comb begin
    evt_set                = fold_errors(err_set);
    evt_set[EVT_QUERY_ERR] = query_fault_i;
    evt_set[EVT_OP_DONE]   = op_done_i;
  end

  // error query clears the event register as well
  assign err_clear = clear_status_i | error_query_i;
  assign evt_clear = clear_status_i | error_query_i |
                     event_query_i;

  always_comb begin
    err_nxt = merge_flags(err_r, err_set, err_clear) &
              ERR_USED_MASK;
  end

  always_comb begin
    evt_nxt = merge_flags(evt_r, evt_set, evt_clear);
  end

  always_comb begin
    error_data_nxt = capture_answer(error_data_o, err_r & ERR_USED_MASK,
                                    error_query_i);
  end

  always_comb begin
    event_data_nxt = capture_answer(event_data_o, evt_r, event_query_i);
  end

  // error bits; bit 7 is already forced low in err_nxt
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      err_r <= ERR_RESET;
    end else begin
      err_r <= err_nxt;
    end
  end

  // power-on flag: the reset value, raised again by every reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      evt_r <= EVT_RESET;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // answer holds the value from before the clear on the same edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      error_data_o <= '0;
    end else begin
      error_data_o <= error_data_nxt;
    end
  end

  // valid pulses for exactly one cycle per query
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      error_valid_o <= 1'b0;
    end else begin
      error_valid_o <= error_query_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      event_data_o <= '0;
    end else begin
      event_data_o <= event_data_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      event_valid_o <= 1'b0;
    end else begin
      event_valid_o <= event_query_i;
    end
  end

  // lets the status byte logic outside clear on the same command
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_clear_o <= 1'b0;
    end else begin
      status_clear_o <= clear_status_i;
    end
  end

  assign error_flags_o   = err_r;
  assign event_flags_o   = evt_r;
  // power-on flag alone raises the summary only if enabled
  assign event_summary_o = |(evt_r & event_enable_i);
endmodule

// file: test/rer_properties.sv
// port-level assertions for the error register bank
`timescale 1ns/100ps
module rer_properties (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       msg_too_long_flag_i,
  input wire logic       bad_header_flag_i,
  input wire logic       internal_link_fault_flag_i,
  input wire logic       clear_status_i,
  input wire logic       error_query_i,
  input wire logic [7:0] event_enable_i,
  input wire logic [7:0] error_data_o,
  input wire logic       error_valid_o,
  input wire logic [7:0] error_flags_o,
  input wire logic [7:0] event_flags_o,
  input wire logic       event_summary_o,
  input wire logic       status_clear_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_bit7_zero: assert property (!error_flags_o[7])
    else $error("error bit 7 set");
  chk_query_data: assert property (error_query_i |=>
    error_valid_o && error_data_o == $past(error_flags_o))
    else $error("query answer wrong");
  chk_valid_cause: assert property (error_valid_o |->
    $past(error_query_i)) else $error("answer without query");
  chk_query_clear: assert property (
    error_query_i && !msg_too_long_flag_i |=> !error_flags_o[6])
    else $error("query left bit 6");
  chk_set_long: assert property (msg_too_long_flag_i |=>
    error_flags_o[6] && event_flags_o[5]) else $error("bit 6 fold");
  chk_set_header: assert property (bad_header_flag_i |=>
    error_flags_o[5]) else $error("bit 5 not set");
  chk_set_link: assert property (internal_link_fault_flag_i |=>
    error_flags_o[1] && event_flags_o[3]) else $error("bit 1 fold");
  chk_clear_all: assert property (
    clear_status_i && !msg_too_long_flag_i |=> status_clear_o &&
    !event_flags_o[7] && !error_flags_o[6]) else $error("clear failed");
  chk_summary_or: assert property (event_summary_o ==
    |(event_flags_o & event_enable_i)) else $error("summary wrong");
  cover property (error_query_i);
  cover property (clear_status_i);
  cover property (event_summary_o);
endmodule

// file: test/rer_host_model.sv
// remote controller model issuing the error query
`timescale 1ns/100ps
module rer_host_model #(parameter int GAP = 5) (
  input  wire logic       clock_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output logic            query_o
);
  initial query_o = 1'b0;
  task automatic query(output logic [7:0] d);
    d = 8'hxx;
    @(posedge clock_i) query_o <= 1'b1;
    @(posedge clock_i) query_o <= 1'b0;
    repeat (4) begin
      @(negedge clock_i);
      if (valid_i === 1'b1) begin
        d = data_i;
        break;
      end
    end
    // spacing shortened from the serial gap to keep runs brief
    repeat (GAP) @(posedge clock_i);
    @(negedge clock_i);
  endtask
endmodule

// file: test/rer_error_bank_tb_top.sv
// self-checking bench for the error register bank
`timescale 1ns/100ps
module rer_error_bank_tb_top;
  import rer_pkg::*;
  logic       clock_i = 1'b0, rst_i = 1'b1, clr = 1'b0, eq = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [7:0] en = 8'h00, d, edat, eflg, vflg, edv;
  logic       q, vld, sum, sclr, evld;
  int         fails = 0, check_count = 0;
  initial forever #10 clock_i = ~clock_i;
  rer_error_bank DUT (.clock_i, .rst_i, .msg_too_long_flag_i(ev[6]),
    .bad_header_flag_i(ev[5]), .bad_format_flag_i(ev[4]),
    .out_of_range_flag_i(ev[3]), .cannot_execute_flag_i(ev[2]),
    .internal_link_fault_flag_i(ev[1]), .backup_damaged_flag_i(ev[0]),
    .query_fault_i(ev[8]), .op_done_i(ev[7]), .clear_status_i(clr),
    .error_query_i(q), .event_query_i(eq), .event_enable_i(en),
    .error_data_o(edat), .error_valid_o(vld), .event_data_o(edv),
    .event_valid_o(evld), .error_flags_o(eflg), .event_flags_o(vflg),
    .event_summary_o(sum), .status_clear_o(sclr));
  rer_host_model HOST (.clock_i, .valid_i(vld), .data_i(edat), .query_o(q));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task pulse(logic [8:0] v);
    @(posedge clock_i) ev <= v;
    @(posedge clock_i) ev <= 9'h000;
    @(negedge clock_i);
  endtask
  task t_bits;
    for (int i = 0; i < 7; i++) begin
      pulse(9'h001 << i);
      HOST.query(d);
      chk("err_data", 8'h01 << i, d);
      chk("err_flags", 8'h00, eflg);
    end
  endtask
  task t_fold;
    @(posedge clock_i) en <= 8'h20;
    pulse(9'h1ff);
    chk("err_flags", 8'h7f, eflg);
    chk("evt_flags", 8'h3d, vflg);
    chk("summary", 8'h01, {7'h00, sum});
    @(posedge clock_i) en <= 8'h02;
    @(negedge clock_i);
    chk("summary", 8'h00, {7'h00, sum});
  endtask
  task t_clear;
    @(posedge clock_i) clr <= 1'b1;
    @(posedge clock_i) clr <= 1'b0;
    @(negedge clock_i);
    chk("cls_regs", 8'h00, vflg | eflg);
    chk("cls_pulse", 8'h01, {7'h00, sclr});
  endtask
  task t_evtq;
    pulse(9'h184);
    @(posedge clock_i) eq <= 1'b1;
    @(posedge clock_i) eq <= 1'b0;
    @(negedge clock_i);
    chk("evt_data", 8'h15, edv);
    chk("evt_valid", 8'h01, {7'h00, evld});
    chk("evt_flags", 8'h00, vflg);
    chk("err_kept", 8'h04, eflg);
    @(negedge clock_i);
    chk("evt_valid", 8'h00, {7'h00, evld});
    chk("evt_data", 8'h15, edv);
  endtask
  task t_reset;
    pulse(9'h040);
    chk("pre_reset", 8'h48, eflg);
    @(posedge clock_i) rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    chk("rst_err", 8'h00, eflg);
    chk("rst_evt", 8'h80, vflg);
  endtask
  task t_same;
    pulse(9'h004);
    fork
      HOST.query(d);
      pulse(9'h008);
    join
    chk("err_data", 8'h04, d);
    chk("err_flags", 8'h08, eflg);
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    chk("reset", 8'h80, vflg | eflg);
    t_bits;
    t_fold;
    t_clear;
    t_evtq;
    t_same;
    t_reset;
    wrap_up;
  end
  initial begin
    #100us;
    fails++;
    wrap_up;
  end
endmodule
bind rer_error_bank rer_properties PROPS (.clock_i, .rst_i,
  .msg_too_long_flag_i, .bad_header_flag_i, .internal_link_fault_flag_i,
  .clear_status_i, .error_query_i, .event_enable_i, .error_data_o,
  .error_valid_o, .error_flags_o, .event_flags_o, .event_summary_o,
  .status_clear_o);
